// ==== logic/gpib_bus_option_regs.svh ====
// Constants for the bus option command handler: characters, parameters, defaults, timing.
// Assumes command bytes arrive as 8-bit ASCII from the bus interface logic.
`ifndef GPIB_BUS_OPTION_REGS_SVH
`define GPIB_BUS_OPTION_REGS_SVH

// Characters
`define CHR_TERM        8'h58
`define CHR_ZERO        8'h30
`define CHR_NINE        8'h39
`define CHR_A           8'h41
`define CHR_Z           8'h5a
`define CHR_EOI_CMD     8'h4b
`define CHR_SETUP_CMD   8'h4c
`define CHR_MASK_CMD    8'h4d

// Parameter limits and values
`define EOI_PARAM_MAX   8'h03
`define SETUP_SAVE      8'h00
`define SETUP_FACTORY   8'h01
`define SETUP_USER      8'h02
`define DEC_TEN         8'h0a

// Status byte and mask layout
`define STS_RQS_BIT     6
`define STS_READY_BIT   4
`define MASK_VALID      8'hbf
`define MASK_DEFAULT    8'h00
`define STS_CLEAR       8'h00

// Command buffer
`define BUF_DEPTH       6'h20
`define BUF_IDX_W       5

// Factory configuration
`define FACT_RESOLUTION 4'h1
`define FACT_DIG_FILT   2'h2
`define FACT_TRIG_MS    16'h00fa
`define FACT_RANGE      4'h5
`define FACT_TRIG_MODE  4'h6
`define FACT_AOUT_GAIN  16'h0001
`define FACT_ZERO_VOLT  32'h0000_0000

// Save or recall busy time
`define SAVE_RECALL_MS  2000
`define CLK_KHZ         200000

`endif

// ==== logic/gpib_bus_option_pkg.sv ====
// Types for the bus option command handler.
// Assumes the constants header is included by the design file.
package gpib_bus_option_pkg;

	// Instrument setup that can be saved and recalled
	typedef struct packed {
		logic [3:0]  resolution;
		logic        aoutRelEn;
		logic        filtersOn;
		logic        analogFilt;
		logic [1:0]  digFilt;
		logic [15:0] trigIntervalMs;
		logic [3:0]  rangeSel;
		logic [1:0]  integPeriod;
		logic [3:0]  trigMode;
		logic [1:0]  aoutSource;
		logic [15:0] aoutGain;
		logic        trigDelayEn;
		logic        rdgRelEn;
		logic [31:0] aoutRelVal;
		logic [31:0] aoutSrcVal;
		logic [31:0] rdgRelVal;
	} cfg_t;

	// Byte offered for a talk transfer
	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       last;
	} talk_t;

	typedef enum logic [2:0] {
		S_COLLECT = 3'b000,
		S_SCAN    = 3'b001,
		S_EXEC    = 3'b010,
		S_BUSY    = 3'b011
	} fsm_t;

	typedef struct packed {
		fsm_t              fsm;
		logic [31:0][7:0]  cmdBuf;
		logic [5:0]        cnt;
		logic [5:0]        ptr;
		logic [7:0]        letter;
		logic [7:0]        param;
		logic              haveCmd;
		logic              eoiEn;
		logic              holdEn;
		logic              nrfdHold;
		logic [7:0]        srqMask;
		logic [7:0]        sts;
		logic              rqs;
		logic [31:0]       timer;
		cfg_t              userCfg;
		cfg_t              applyCfg;
		logic              cfgLoad;
		logic [7:0]        talkData;
		logic              talkEoi;
		logic              talkValid;
		logic              overrun;
	} state_t;

endpackage

// ==== logic/gpib_bus_option_handler.sv ====
// Command handler for the EOI/hold-off, save/recall and service-request mask commands.
// Assumes a bus interface on clk_sys delivering command bytes, clear and serial-poll pulses.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_bus_option_regs.svh"

module gpib_bus_option_handler #(
	parameter int unsigned SAVE_RECALL_CYCLES = `SAVE_RECALL_MS * `CLK_KHZ
) (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	// Command bytes from the bus interface
	input  wire logic [7:0]                  cmdByte,
	input  wire logic                        cmdValid,
	input  wire logic                        devClear,
	// Serial poll
	input  wire logic                        spollRead,
	output logic      [7:0]                  statusByte,
	output logic                             srqActive,
	// Status conditions from the instrument
	input  wire logic [7:0]                  stsSet,
	input  wire logic [7:0]                  stsClr,
	// Talk path
	input  wire gpib_bus_option_pkg::talk_t  talkIn,
	output logic      [7:0]                  talkData,
	output logic                             talkValid,
	output logic                             talkEoi,
	// Bus handshake hold
	output logic                             nrfdHold,
	// Setup exchange with the instrument
	input  wire gpib_bus_option_pkg::cfg_t   cfgCurrent,
	output gpib_bus_option_pkg::cfg_t        cfgApply,
	output logic                             cfgLoad,
	// Settings seen by the instrument
	output logic                             eoiEnabled,
	output logic                             holdEnabled,
	output logic      [7:0]                  srqMask,
	output logic                             cmdOverrun,
	output logic                             cmdBusy
);

	gpib_bus_option_pkg::state_t cur;
	gpib_bus_option_pkg::state_t nxt;
	logic [7:0] curChar;
	logic [7:0] newCond;
	logic       newReq;
	logic       execNow;

	function automatic logic isDigit(input logic [7:0] c);
		return (c >= `CHR_ZERO) && (c <= `CHR_NINE);
	endfunction

	function automatic gpib_bus_option_pkg::cfg_t factoryCfg();
		gpib_bus_option_pkg::cfg_t f;
		f = '0;
		f.resolution     = `FACT_RESOLUTION;
		f.filtersOn      = 1'b1;
		f.digFilt        = `FACT_DIG_FILT;
		f.trigIntervalMs = `FACT_TRIG_MS;
		f.rangeSel       = `FACT_RANGE;
		f.trigMode       = `FACT_TRIG_MODE;
		f.aoutGain       = `FACT_AOUT_GAIN;
		f.aoutRelVal     = `FACT_ZERO_VOLT;
		f.aoutSrcVal     = `FACT_ZERO_VOLT;
		f.rdgRelVal      = `FACT_ZERO_VOLT;
		return f;
	endfunction

	assign curChar = cur.cmdBuf[cur.ptr[`BUF_IDX_W-1:0]];
	assign execNow = (cur.fsm == gpib_bus_option_pkg::S_EXEC);

	always_comb begin
		nxt = cur;
		// Conditions newly set whose mask bit is already on
		newCond = stsSet & ~cur.sts;
		if (cur.fsm == gpib_bus_option_pkg::S_SCAN && cur.ptr == cur.cnt && !cur.haveCmd) begin
			newCond[`STS_READY_BIT] = ~cur.sts[`STS_READY_BIT];
		end
		newCond[`STS_RQS_BIT] = 1'b0;
		newReq = |(newCond & cur.srqMask);
		nxt.cfgLoad   = 1'b0;
		nxt.talkValid = talkIn.valid;
		if (talkIn.valid) begin
			nxt.talkData = talkIn.data;
			nxt.talkEoi  = talkIn.last && cur.eoiEn;
		end

		// Status conditions: set wins over clear
		nxt.sts = (cur.sts & ~stsClr) | stsSet;
		nxt.sts[`STS_RQS_BIT] = 1'b0;
		if (spollRead) begin
			nxt.rqs = 1'b0;
		end
		if (newReq) begin
			nxt.rqs = 1'b1;
		end

		case (cur.fsm)
			gpib_bus_option_pkg::S_COLLECT: begin
				if (cmdValid) begin
					if (cmdByte == `CHR_TERM) begin
						nxt.fsm     = gpib_bus_option_pkg::S_SCAN;
						nxt.ptr     = '0;
						nxt.haveCmd = 1'b0;
						nxt.sts[`STS_READY_BIT] = 1'b0;
					end else if (cur.cnt == `BUF_DEPTH) begin
						nxt.overrun = 1'b1;
					end else begin
						nxt.cmdBuf[cur.cnt[`BUF_IDX_W-1:0]] = cmdByte;
						nxt.cnt = cur.cnt + 6'h01;
					end
				end
			end
			gpib_bus_option_pkg::S_SCAN: begin
				if (cur.ptr == cur.cnt) begin
					if (cur.haveCmd) begin
						nxt.fsm = gpib_bus_option_pkg::S_EXEC;
					end else begin
						nxt.fsm = gpib_bus_option_pkg::S_COLLECT;
						nxt.cnt = '0;
						nxt.overrun = 1'b0;
						nxt.sts[`STS_READY_BIT] = 1'b1;
					end
				end else if (isDigit(curChar) && cur.haveCmd) begin
					nxt.param = 8'(cur.param * `DEC_TEN + (curChar - `CHR_ZERO));
					nxt.ptr   = cur.ptr + 6'h01;
				end else if (curChar >= `CHR_A && curChar <= `CHR_Z) begin
					if (cur.haveCmd) begin
						nxt.fsm = gpib_bus_option_pkg::S_EXEC;
					end else begin
						nxt.letter  = curChar;
						nxt.param   = '0;
						nxt.haveCmd = 1'b1;
						nxt.ptr     = cur.ptr + 6'h01;
					end
				end else begin
					nxt.ptr = cur.ptr + 6'h01;
				end
			end
			gpib_bus_option_pkg::S_EXEC: begin
				nxt.haveCmd = 1'b0;
				nxt.fsm     = gpib_bus_option_pkg::S_SCAN;
				if (cur.letter == `CHR_EOI_CMD) begin
					if (cur.param <= `EOI_PARAM_MAX) begin
						nxt.eoiEn  = ~cur.param[0];
						nxt.holdEn = ~cur.param[1];
					end
				end else if (cur.letter == `CHR_MASK_CMD) begin
					nxt.srqMask = cur.param & `MASK_VALID;
				end else if (cur.letter == `CHR_SETUP_CMD) begin
					if (cur.param == `SETUP_SAVE) begin
						nxt.userCfg = cfgCurrent;
					end else if (cur.param == `SETUP_FACTORY) begin
						nxt.applyCfg = factoryCfg();
						nxt.cfgLoad  = 1'b1;
					end else if (cur.param == `SETUP_USER) begin
						nxt.applyCfg = cur.userCfg;
						nxt.cfgLoad  = 1'b1;
					end
					if (cur.param <= `SETUP_USER) begin
						nxt.eoiEn   = 1'b1;
						nxt.holdEn  = 1'b1;
						nxt.srqMask = `MASK_DEFAULT;
						nxt.timer   = '0;
						nxt.fsm     = gpib_bus_option_pkg::S_BUSY;
					end
				end
			end
			gpib_bus_option_pkg::S_BUSY: begin
				// Commands stay parked in the buffer until the save or recall ends
				if (cur.timer >= 32'(SAVE_RECALL_CYCLES - 1)) begin
					nxt.fsm = gpib_bus_option_pkg::S_SCAN;
				end else begin
					nxt.timer = cur.timer + 32'h1;
				end
			end
			default: begin
				nxt.fsm = gpib_bus_option_pkg::S_COLLECT;
			end
		endcase

		// Device clear behaves like power-up for the bus-side state
		if (devClear) begin
			nxt.fsm      = gpib_bus_option_pkg::S_COLLECT;
			nxt.cnt      = '0;
			nxt.haveCmd  = 1'b0;
			nxt.overrun  = 1'b0;
			nxt.eoiEn    = 1'b1;
			nxt.holdEn   = 1'b1;
			nxt.srqMask  = `MASK_DEFAULT;
			nxt.sts      = `STS_CLEAR;
			nxt.rqs      = 1'b0;
			nxt.applyCfg = cur.userCfg;
			nxt.cfgLoad  = 1'b1;
		end

		nxt.nrfdHold = (nxt.fsm != gpib_bus_option_pkg::S_COLLECT) && nxt.holdEn;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur          <= '0;
			cur.fsm      <= gpib_bus_option_pkg::S_COLLECT;
			cur.eoiEn    <= 1'b1;
			cur.holdEn   <= 1'b1;
			cur.userCfg  <= factoryCfg();
			cur.applyCfg <= factoryCfg();
			cur.cfgLoad  <= 1'b1;
		end else begin
			cur <= nxt;
		end
	end

	assign statusByte  = {cur.sts[7], cur.rqs, cur.sts[5:0]};
	assign srqActive   = cur.rqs;
	assign talkData    = cur.talkData;
	assign talkValid   = cur.talkValid;
	assign talkEoi     = cur.talkEoi;
	assign nrfdHold    = cur.nrfdHold;
	assign cfgApply    = cur.applyCfg;
	assign cfgLoad     = cur.cfgLoad;
	assign eoiEnabled  = cur.eoiEn;
	assign holdEnabled = cur.holdEn;
	assign srqMask     = cur.srqMask;
	assign cmdOverrun  = cur.overrun;
	assign cmdBusy     = (cur.fsm != gpib_bus_option_pkg::S_COLLECT);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_eoi_cmd;
		execNow && cur.letter == `CHR_EOI_CMD && cur.param <= `EOI_PARAM_MAX && !devClear
			|=> eoiEnabled == !$past(cur.param[0]) && holdEnabled == !$past(cur.param[1]);
	endproperty
	a_eoi_cmd: assert property (p_eoi_cmd) else $error("EOI/hold-off setting wrong");

	property p_clear_defaults;
		devClear |=> eoiEnabled && holdEnabled && srqMask == 8'h00 && cfgLoad;
	endproperty
	a_clear_defaults: assert property (p_clear_defaults) else $error("Clear defaults wrong");

	property p_talk_eoi;
		talkIn.valid |=> talkValid && talkEoi == ($past(talkIn.last) && $past(eoiEnabled));
	endproperty
	a_talk_eoi: assert property (p_talk_eoi) else $error("EOI on talk byte wrong");

	property p_hold_on_term;
		cur.fsm == gpib_bus_option_pkg::S_COLLECT && cmdValid && cmdByte == `CHR_TERM
			&& holdEnabled && !devClear |=> nrfdHold && cmdBusy;
	endproperty
	a_hold_on_term: assert property (p_hold_on_term) else $error("NRFD not held");

	property p_save_user;
		execNow && cur.letter == `CHR_SETUP_CMD && cur.param == `SETUP_SAVE && !devClear
			|=> cur.userCfg == $past(cfgCurrent) && !cfgLoad;
	endproperty
	a_save_user: assert property (p_save_user) else $error("User setup not saved");

	property p_factory;
		execNow && cur.letter == `CHR_SETUP_CMD && cur.param == `SETUP_FACTORY && !devClear
			|=> cfgLoad && cfgApply == factoryCfg() && cfgApply.trigIntervalMs == 16'h00fa;
	endproperty
	a_factory: assert property (p_factory) else $error("Factory setup not loaded");

	property p_busy_hold;
		cur.fsm == gpib_bus_option_pkg::S_BUSY && !devClear
			|=> nrfdHold && cur.fsm != gpib_bus_option_pkg::S_EXEC;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("Busy period not held");

	property p_setup_mask;
		execNow && cur.letter == `CHR_SETUP_CMD && cur.param <= `SETUP_USER && !devClear
			|=> srqMask == 8'h00 && cur.fsm == gpib_bus_option_pkg::S_BUSY;
	endproperty
	a_setup_mask: assert property (p_setup_mask) else $error("Mask not reset");

	property p_clear_status;
		devClear |=> statusByte == 8'h00 && !srqActive;
	endproperty
	a_clear_status: assert property (p_clear_status) else $error("Status not cleared");

	property p_no_late_srq;
		!srqActive && !newReq |=> !srqActive;
	endproperty
	a_no_late_srq: assert property (p_no_late_srq) else $error("SRQ without masked cause");

	property p_spoll_clear;
		spollRead && !newReq |=> !statusByte[6];
	endproperty
	a_spoll_clear: assert property (p_spoll_clear) else $error("RQS not cleared by poll");

	property p_buffered;
		cur.fsm == gpib_bus_option_pkg::S_COLLECT && cmdValid && cmdByte != `CHR_TERM
			&& !devClear |=> !cmdBusy && !cfgLoad;
	endproperty
	a_buffered: assert property (p_buffered) else $error("Command acted before terminator");

	c_save: cover property (execNow && cur.letter == `CHR_SETUP_CMD && cur.param == `SETUP_SAVE);
	c_srq: cover property (newReq ##[1:20] spollRead);
	c_eoi: cover property (talkValid && talkEoi);
	c_busy_end: cover property (cur.fsm == gpib_bus_option_pkg::S_BUSY
		##1 cur.fsm == gpib_bus_option_pkg::S_SCAN);

endmodule
`default_nettype wire

// ==== verification/bus_ctrl_model.sv ====
// Bus controller model: sends command strings, serial-polls, counts finished reads.
// Assumes the handler samples command bytes and poll pulses on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
	// Clock
	input  wire logic       clk_sys,
	// Talk side of the handler
	input  wire logic       talkValid,
	input  wire logic       talkEoi,
	input  wire logic [7:0] talkData,
	input  wire logic       eoiOn,
	// Command side of the handler
	output logic      [7:0] cmdByte,
	output logic            cmdValid,
	output logic            spollRead,
	output logic      [7:0] readsDone
);
	initial begin
		cmdByte = 8'h00;
		cmdValid = 1'b0;
		spollRead = 1'b0;
		readsDone = 8'h00;
	end

	// Ends a read on EOI, or on the line feed when EOI was switched off
	always @(posedge clk_sys) begin
		if (talkValid && (eoiOn ? talkEoi : talkData == 8'h0a)) begin
			readsDone <= readsDone + 8'h01;
		end
	end

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_sys);
			#1 cmdByte = s[i];
			cmdValid = 1'b1;
		end
		@(posedge clk_sys);
		#1 cmdValid = 1'b0;
		cmdByte = ~cmdByte;
	endtask

	// Reading the status byte releases the request
	task automatic spoll();
		@(posedge clk_sys);
		#1 spollRead = 1'b1;
		@(posedge clk_sys);
		#1 spollRead = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verification/gpib_bus_option_handler_tb.sv ====
// Self-checking bench for the bus option command handler.
// Assumes the handler package is compiled first; a short save/recall time is set.
`timescale 1ns/1ps
`default_nettype none
module gpib_bus_option_handler_tb;
	logic                      clk_sys = 1'b0;
	logic                      sys_rst, cmdValid, devClear, spollRead, srqActive;
	logic                      talkValid, talkEoi, nrfdHold, cfgLoad, cmdBusy, cmdOverrun;
	logic                      eoiEnabled, holdEnabled, eoiM, holdM;
	logic [7:0]                cmdByte, statusByte, talkData, srqMask, stsSet, stsClr;
	logic [7:0]                readsDone, maskM;
	logic [191:0]              rnd;
	gpib_bus_option_pkg::talk_t talkIn;
	gpib_bus_option_pkg::cfg_t  cfgCurrent, cfgApply, lastApply, userM;
	int                        errors, checksDone, loads, loadsM, readsM, m;
	int                        seed = 14107;

	always #2.5 clk_sys = ~clk_sys;

	gpib_bus_option_handler #(.SAVE_RECALL_CYCLES(10)) dut (
		.clk_sys, .sys_rst, .cmdByte, .cmdValid, .devClear, .spollRead, .statusByte,
		.srqActive, .stsSet, .stsClr, .talkIn, .talkData, .talkValid, .talkEoi, .nrfdHold,
		.cfgCurrent, .cfgApply, .cfgLoad, .eoiEnabled, .holdEnabled, .srqMask, .cmdOverrun,
		.cmdBusy);

	bus_ctrl_model u_ctl (.clk_sys, .talkValid, .talkEoi, .talkData, .eoiOn(eoiM), .cmdByte,
		.cmdValid, .spollRead, .readsDone);

	// Captures every applied setup
	always @(posedge clk_sys) begin
		if (cfgLoad === 1'b1 && sys_rst === 1'b0) begin
			lastApply <= cfgApply;
			loads <= loads + 1;
		end
	end

	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (cmdBusy !== 1'b0 && n < 100) begin
			@(posedge clk_sys);
			#1 n++;
		end
		if (n == 100) chk("idleWait", 1, 0);
	endtask

	task automatic apply(input byte l, input int p);
		if (l == "K" && p < 4) begin
			eoiM = !p[0];
			holdM = !p[1];
		end
		if (l == "M") maskM = 8'(p) & 8'hbf;
		if (l == "L" && p < 3) begin
			eoiM = 1'b1;
			holdM = 1'b1;
			maskM = 8'h00;
			if (p == 0) userM = cfgCurrent;
			if (p > 0) loadsM++;
		end
	endtask

	// Model parses the string, then the controller sends it
	task automatic cmd(input string s, input bit mid = 1'b0);
		byte l;
		int  p;
		logic hb;
		hb = holdM;
		l = 0;
		p = 0;
		for (int i = 0; i < s.len(); i++) begin
			if (s[i] >= 8'h30 && s[i] <= 8'h39) p = (p * 10 + s[i] - 8'h30) % 256;
			else if (s[i] != ",") begin
				apply(l, p);
				l = s[i];
				p = 0;
			end
		end
		u_ctl.send_str(s);
		chk("nrfdHold", nrfdHold, hb);
		chk("cmdBusy", cmdBusy, 1);
		if (mid) begin
			// Save of the mid-run scenario starts 13 cycles after its terminator
			repeat (12) @(posedge clk_sys);
			u_ctl.send_str("K3X");
			chk("busyHold", {cmdBusy, nrfdHold}, 2'b11);
		end
		wait_idle();
		@(posedge clk_sys);
		#1 chk("eoiHold", {eoiEnabled, holdEnabled}, {eoiM, holdM});
		chk("srqMask", srqMask, maskM);
		chk("loads", loads, loadsM);
	endtask

	task automatic sts(input logic [7:0] s, input logic [7:0] c);
		@(posedge clk_sys);
		#1 stsSet = s;
		stsClr = c;
		@(posedge clk_sys);
		#1 stsSet = 8'h00;
		stsClr = 8'h00;
	endtask

	task automatic talk(input bit lst);
		logic [7:0] d;
		d = lst ? 8'h0a : {1'b1, 7'($random(seed))};
		@(posedge clk_sys);
		#1 talkIn = '{data: d, valid: 1'b1, last: lst};
		@(posedge clk_sys);
		#1 talkIn.valid = 1'b0;
		chk("talkData", {talkValid, talkData}, {1'b1, d});
		chk("talkEoi", talkEoi, lst && eoiM);
		if (lst) readsM++;
	endtask

	task automatic chk_factory();
		chk("trigMs", lastApply.trigIntervalMs, 16'h00fa);
		chk("aoutGain", {lastApply.aoutGain, lastApply.aoutSource}, 18'h00004);
		chk("zeroVals", lastApply.aoutRelVal | lastApply.aoutSrcVal | lastApply.rdgRelVal, 0);
	endtask

	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end

	initial begin
		{sys_rst, devClear, stsSet, stsClr, talkIn, cfgCurrent} = '0;
		sys_rst = 1'b1;
		{eoiM, holdM, maskM, loads, loadsM, readsM} = {2'b11, 8'h00, 32'd0, 32'd1, 32'd0};
		repeat (5) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk("eoiHoldRst", {eoiEnabled, holdEnabled, srqMask}, 10'h300);
		chk("stsRst", {statusByte, srqActive, nrfdHold}, 0);
		chk("loadsRst", loads, 1);
		chk_factory();
		for (int k = 0; k < 4; k++) begin
			cmd($sformatf("K%0dX", k));
			talk(1'b1);
			talk(1'b0);
		end
		cmd("K5X");
		cmd("K1,K2X");
		chk("readsDone", readsDone, readsM);
		m = ($random(seed) & 8'hac) | 8'h01;
		cmd($sformatf("M%0dX", m));
		sts(8'h03, 8'h00);
		chk("srqRaise", {srqActive, statusByte}, 9'h153);
		u_ctl.spoll();
		chk("srqPoll", {srqActive, statusByte}, 9'h013);
		cmd("M2X");
		chk("srqLate", srqActive, 0);
		sts(8'h00, 8'h03);
		sts(8'h02, 8'h00);
		chk("srqNew", srqActive, 1);
		u_ctl.spoll();
		cmd("M0X");
		sts(8'hef, 8'h00);
		chk("srqOff", srqActive, 0);
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed)};
		cfgCurrent = rnd[$bits(gpib_bus_option_pkg::cfg_t)-1:0];
		cmd("K3M33L0X", 1'b1);
		cfgCurrent = ~cfgCurrent;
		cmd("K3L1X");
		chk_factory();
		cmd("M160L2X");
		chk("userCfg", lastApply === userM, 1);
		cmd("K3M1X");
		sts(8'h00, 8'hff);
		sts(8'h01, 8'h00);
		chk("srqSet", srqActive, 1);
		@(posedge clk_sys);
		#1 devClear = 1'b1;
		@(posedge clk_sys);
		#1 devClear = 1'b0;
		chk("clrLoad", {cfgLoad, cfgApply === userM}, 2'b11);
		chk("clrSts", {statusByte, srqActive}, 0);
		chk("clrSet", {eoiEnabled, holdEnabled, srqMask}, 10'h300);
		tally_and_finish();
	end
endmodule
`default_nettype wire
